// File: hdl/data_space_io_decoder.sv
`timescale 1ns/1ps
// Function
// - map 32 regs, 64 std io, 160 ext io
// - sram follows extended io region
// - ext io only via load/store
// - direct address reaches whole data space
// - displacement mode adds up to 63
// - io address plus 0x20 gives data address
// - bit ops only on io 0x00-0x1f
// - bit ops touch only addressed bit
// - writing one clears status flags
// - eeprom read halts cpu four cycles
// - eeprom write halts cpu two cycles
// - eeprom is separate byte address space
// - self timed write with pollable done flag
// - write finishes despite system reset
// - write needs arm then strobe sequence
// - eeprom registers live in io space
// - store register 0x4b, reset zero
module data_space_io_decoder #(
  parameter int PROG_CYC = dspace_pkg::EE_PROG_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic por_n,
  // cpu data path
  input wire dspace_pkg::op_t op,
  input wire logic [15:0] base_addr,
  input wire logic [5:0] disp,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // cpu io path
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [5:0] io_addr,
  input wire logic set_io_bit_op,
  input wire logic clear_io_bit_op,
  input wire logic skip_if_io_bit_set,
  input wire logic skip_if_io_bit_clear,
  input wire logic [2:0] bit_sel,
  output logic skip,
  // regions outside this block
  output logic [4:0] reg_idx,
  output logic reg_sel,
  output logic ext_sel,
  output logic [9:0] sram_idx,
  output logic sram_sel,
  input wire logic [7:0] ext_rdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] sram_rdata,
  // events and status
  input wire logic flag_event,
  output logic cpu_stall
);
  logic [15:0] eff_addr;
  logic [15:0] io_data_addr;
  logic [15:0] acc_addr;
  logic data_wr;
  logic data_rd;
  logic any_wr;
  logic [5:0] std_idx;
  logic std_hit;
  logic bit_ok;
  logic [7:0] std_cur;
  logic [7:0] std_new;
  logic [7:0] bit_mask;
  logic hit_store2;
  logic hit_ctrl;
  logic hit_edat;
  logic hit_eal;
  logic hit_eah;
  logic hit_flag;
  logic [7:0] store2_r;
  logic [7:0] edat_r;
  logic [8:0] eadr_r;
  logic arm_r;
  logic [2:0] arm_cnt_r;
  logic [7:0] flag_r;
  logic ee_busy;
  logic [7:0] ee_rdata;
  logic ee_rd_go;
  logic ee_wr_go;
  logic [7:0] ctrl_val;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic skip_r;
  logic bit_solo;
  logic arm_set;
  logic ee_rd_dly_r;

  // effective data address: base plus unsigned displacement
  assign eff_addr = base_addr + {10'h000, disp};
  assign io_data_addr = {10'h000, io_addr} + dspace_pkg::IO_OFFSET;
  assign bit_ok = (io_addr <= dspace_pkg::IO_BIT_TOP);
  assign data_wr = (op == dspace_pkg::OP_STORE);
  assign data_rd = (op == dspace_pkg::OP_LOAD);
  // io path can only ever produce 0x20-0x5f, so extended io is unreachable
  assign acc_addr = (data_wr || data_rd) ? eff_addr : io_data_addr;

  // region decode
  assign reg_sel = (data_wr || data_rd) && (acc_addr < dspace_pkg::STDIO_BASE);
  assign reg_idx = acc_addr[4:0];
  assign std_hit = (acc_addr >= dspace_pkg::STDIO_BASE) && (acc_addr < dspace_pkg::EXTIO_BASE);
  assign std_idx = 6'(acc_addr - dspace_pkg::IO_OFFSET);
  assign ext_sel = (data_wr || data_rd) && (acc_addr >= dspace_pkg::EXTIO_BASE)
                   && (acc_addr < dspace_pkg::SRAM_BASE);
  assign sram_sel = (data_wr || data_rd) && (acc_addr >= dspace_pkg::SRAM_BASE)
                    && (acc_addr < dspace_pkg::DATA_TOP);
  assign sram_idx = 10'(acc_addr - dspace_pkg::SRAM_BASE);

  // standard io register hits
  assign hit_store2 = std_hit && (acc_addr == dspace_pkg::STORE2_OFFSET);
  assign hit_ctrl = std_hit && (std_idx == dspace_pkg::EE_CTRL_IO);
  assign hit_edat = std_hit && (std_idx == dspace_pkg::EE_DATA_IO);
  assign hit_eal = std_hit && (std_idx == dspace_pkg::EE_ADDRL_IO);
  assign hit_eah = std_hit && (std_idx == dspace_pkg::EE_ADDRH_IO);
  assign hit_flag = std_hit && (std_idx == dspace_pkg::FLAG_IO);

  assign ctrl_val = {4'h0, !ee_busy, arm_r, 2'b00};
  // unmapped io reads zero
  assign std_cur = hit_store2 ? store2_r :
                   hit_ctrl ? ctrl_val :
                   hit_edat ? edat_r :
                   hit_eal ? eadr_r[7:0] :
                   hit_eah ? {7'h00, eadr_r[8]} :
                   hit_flag ? flag_r : 8'h00;

  // bit operations write only the selected bit; on the w1c flags and on the
  // control strobes the other bits go out as zero, so neighbouring flags
  // survive and a set of one strobe cannot re-fire the arm bit read back
  assign bit_mask = 8'h01 << bit_sel;
  assign any_wr = data_wr || io_wr || ((set_io_bit_op || clear_io_bit_op) && bit_ok);
  assign bit_solo = hit_flag || hit_ctrl;
  assign std_new = set_io_bit_op ? (bit_solo ? bit_mask : (std_cur | bit_mask)) :
                   clear_io_bit_op ? (bit_solo ? 8'h00 : (std_cur & ~bit_mask)) :
                   wdata;

  // eeprom strobes: write only inside arm window and only when idle
  assign ee_rd_go = any_wr && hit_ctrl && std_new[dspace_pkg::EE_RD_BIT] && !ee_busy;
  assign ee_wr_go = any_wr && hit_ctrl && std_new[dspace_pkg::EE_WR_BIT] && arm_r && !ee_busy;
  assign arm_set = any_wr && hit_ctrl && std_new[dspace_pkg::EE_MWE_BIT];

  // a cpu write to the data register beats an eeprom read landing in it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      store2_r <= dspace_pkg::STORE2_RESET;
      edat_r <= 8'h00;
      eadr_r <= 9'h000;
    end else begin
      if (any_wr && hit_store2) store2_r <= std_new;
      if (any_wr && hit_edat) begin
        edat_r <= std_new;
      end else if (ee_rd_dly_r) begin
        edat_r <= ee_rdata;
      end
      if (any_wr && hit_eal) eadr_r[7:0] <= std_new;
      if (any_wr && hit_eah) eadr_r[8] <= std_new[0];
    end
  end

  // arm bit self clears after a short window
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arm_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (arm_set) begin
      arm_r <= 1'b1;
      arm_cnt_r <= 3'(dspace_pkg::EE_ARM_WINDOW);
    end else if (arm_cnt_r != 3'h0) begin
      arm_cnt_r <= arm_cnt_r - 3'h1;
      arm_r <= (arm_cnt_r != 3'h1) && !ee_wr_go;
    end
  end

  // sticky status flags; a new event beats a write-one clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 8'h00;
    end else begin
      flag_r <= (flag_r & ~((any_wr && hit_flag) ? std_new : 8'h00)) | {7'h00, flag_event};
    end
  end

  // read data, skip result, and the delay that lands eeprom read data
  // one cycle after the engine has latched it
  assign rdata_nxt = reg_sel ? reg_rdata :
                     ext_sel ? ext_rdata :
                     sram_sel ? sram_rdata :
                     std_cur;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
      skip_r <= 1'b0;
      ee_rd_dly_r <= 1'b0;
    end else begin
      ee_rd_dly_r <= ee_rd_go;
      if (data_rd || io_rd) rdata_r <= rdata_nxt;
      skip_r <= bit_ok && ((skip_if_io_bit_set && std_cur[bit_sel]) ||
                (skip_if_io_bit_clear && !std_cur[bit_sel]));
    end
  end
  assign rdata = rdata_r;
  assign skip = skip_r;

  // eeprom array holds its own clock of a write across system reset
  ee_engine #(.PROG_CYC(PROG_CYC)) u_ee (
    .ref_clk(ref_clk),
    .por_n(por_n),
    .addr(eadr_r),
    .wdata(edat_r),
    .rd_go(ee_rd_go),
    .wr_go(ee_wr_go),
    .rdata(ee_rdata),
    .busy(ee_busy)
  );

  // cpu halt after eeprom strobes
  stall_timer u_stall (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(ee_rd_go || ee_wr_go),
    .cycles(ee_rd_go ? 3'(dspace_pkg::EE_RD_STALL) : 3'(dspace_pkg::EE_WR_STALL)),
    .stall(cpu_stall)
  );

  a_rd_stall: assert property (@(posedge ref_clk) disable iff (!rstn)
    ee_rd_go |=> cpu_stall [*4] ##1 !cpu_stall) else $error("read halt not four cycles");
  a_wr_stall: assert property (@(posedge ref_clk) disable iff (!rstn)
    ee_wr_go |=> cpu_stall [*2] ##1 !cpu_stall) else $error("write halt not two cycles");
  a_store_rw: assert property (@(posedge ref_clk) disable iff (!rstn)
    (data_wr && acc_addr == dspace_pkg::STORE2_OFFSET) |=> store2_r == $past(wdata))
    else $error("store register not written");
  a_extio_guard: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((io_rd || io_wr || set_io_bit_op || clear_io_bit_op) && op == dspace_pkg::OP_NONE)
    |-> !ext_sel && !sram_sel && (acc_addr < dspace_pkg::EXTIO_BASE)) else $error("io path hit extended io");
  a_sram_map: assert property (@(posedge ref_clk) disable iff (!rstn)
    sram_sel |-> (({6'h00, sram_idx} + dspace_pkg::SRAM_BASE) == eff_addr)) else $error("sram index wrong");
  a_bit_only: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((set_io_bit_op || clear_io_bit_op) && bit_ok && hit_flag && !flag_event)
    |=> (flag_r & ~$past(bit_mask)) == ($past(flag_r) & ~$past(bit_mask))) else $error("bit op disturbed other bits");
  a_flag_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
    flag_event |=> flag_r[0]) else $error("flag event lost");
  a_arm_needed: assert property (@(posedge ref_clk) disable iff (!rstn)
    ee_wr_go |-> $past(arm_set, 1) || $past(arm_set, 2) || $past(arm_set, 3) || $past(arm_set, 4))
    else $error("write started outside arm window");
  a_done_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    ee_wr_go |=> ee_busy && !ctrl_val[dspace_pkg::EE_DONE_BIT]) else $error("done flag not low");
  a_arm_expire: assert property (@(posedge ref_clk) disable iff (!rstn)
    (arm_cnt_r == 3'h0) |-> !arm_r) else $error("arm outlived its window");
  a_stall_start: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!ee_rd_go && !ee_wr_go && !cpu_stall) |=> !cpu_stall) else $error("halt without eeprom strobe");

  // region map: each data-space guard reads the raw address, not the select logic
  a_reg_map: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((data_wr || data_rd) && eff_addr < dspace_pkg::STDIO_BASE) |-> reg_sel && reg_idx == eff_addr[4:0])
    else $error("register file not selected");
  a_std_map: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((data_wr || data_rd) && eff_addr >= dspace_pkg::STDIO_BASE && eff_addr < dspace_pkg::EXTIO_BASE)
    |-> std_hit && !reg_sel && !ext_sel && !sram_sel) else $error("standard io not selected");
  a_ext_map: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((data_wr || data_rd) && eff_addr >= dspace_pkg::EXTIO_BASE && eff_addr < dspace_pkg::SRAM_BASE)
    |-> ext_sel && !std_hit && !sram_sel) else $error("extended io not selected");
  a_sram_top: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((data_wr || data_rd) && eff_addr >= dspace_pkg::DATA_TOP)
    |-> !reg_sel && !std_hit && !ext_sel && !sram_sel) else $error("address above sram selected");
  a_io_offset: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((io_rd || io_wr) && op == dspace_pkg::OP_NONE) |-> std_hit && std_idx == io_addr)
    else $error("io address offset wrong");

  // register behaviour seen from the cpu
  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (io_rd && op == dspace_pkg::OP_NONE && !(hit_store2 || hit_ctrl || hit_edat || hit_eal || hit_eah || hit_flag))
    |=> rdata == 8'h00) else $error("unmapped io read not zero");
  a_skip_range: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((skip_if_io_bit_set || skip_if_io_bit_clear) && !bit_ok) |=> !skip)
    else $error("skip test above bit range");
  a_w1c_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    (io_wr && op == dspace_pkg::OP_NONE && hit_flag && wdata[0] && !flag_event) |=> !flag_r[0])
    else $error("write one did not clear flag");
  a_store_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(any_wr && hit_store2) |=> $stable(store2_r)) else $error("store register changed unwritten");
  a_eadr_hi: assert property (@(posedge ref_clk) disable iff (!rstn)
    (io_wr && op == dspace_pkg::OP_NONE && hit_eah) |=> {7'h00, eadr_r[8]} == ($past(wdata) & 8'h01))
    else $error("eeprom high address bit wrong");
  a_eadr_lo: assert property (@(posedge ref_clk) disable iff (!rstn)
    (io_wr && op == dspace_pkg::OP_NONE && hit_eal) |=> eadr_r[7:0] == $past(wdata))
    else $error("eeprom low address wrong");

  // main scenarios
  c_ee_read: cover property (@(posedge ref_clk) ee_rd_go);
  c_flag_clear: cover property (@(posedge ref_clk) any_wr && hit_flag && flag_r[0]);
  c_ee_write: cover property (@(posedge ref_clk) ee_wr_go);
  c_skip: cover property (@(posedge ref_clk) skip);
  c_sram: cover property (@(posedge ref_clk) sram_sel && data_wr);
endmodule

// File: common/dspace_pkg.sv
package dspace_pkg;
  // data space map
  localparam logic [15:0] REGFILE_BASE = 16'h0000;
  localparam int REGFILE_SIZE = 32;
  localparam logic [15:0] STDIO_BASE = 16'h0020;
  localparam int STDIO_SIZE = 64;
  localparam logic [15:0] EXTIO_BASE = 16'h0060;
  localparam int EXTIO_SIZE = 160;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam int SRAM_SIZE = 1024;
  localparam logic [15:0] DATA_TOP = 16'h0500;
  // i/o view offset
  localparam logic [15:0] IO_OFFSET = 16'h0020;
  localparam logic [5:0] IO_BIT_TOP = 6'h1f;
  localparam int DISP_MAX = 63;
  // storage register
  localparam logic [15:0] STORE2_OFFSET = 16'h004b;
  localparam logic [7:0] STORE2_RESET = 8'h00;
  // eeprom access and status flag registers, i/o addresses
  localparam logic [5:0] EE_CTRL_IO = 6'h1f;
  localparam logic [5:0] EE_DATA_IO = 6'h20;
  localparam logic [5:0] EE_ADDRL_IO = 6'h21;
  localparam logic [5:0] EE_ADDRH_IO = 6'h22;
  localparam logic [5:0] FLAG_IO = 6'h16;
  // eeprom control bits and array size
  localparam int EE_RD_BIT = 0;
  localparam int EE_WR_BIT = 1;
  localparam int EE_MWE_BIT = 2;
  localparam int EE_DONE_BIT = 3;
  localparam int EE_SIZE = 512;
  // timing
  localparam int EE_RD_STALL = 4;
  localparam int EE_WR_STALL = 2;
  localparam int EE_ARM_WINDOW = 4;
  localparam real EE_PROG_US = 3400.0;
  localparam real CLK_MHZ = 40.0;
  localparam int EE_PROG_CYC = int'(EE_PROG_US * CLK_MHZ);
  typedef enum logic [1:0] {OP_NONE = 2'b00, OP_LOAD = 2'b01, OP_STORE = 2'b10} op_t;
endpackage

// File: hdl/stall_timer.sv
`timescale 1ns/1ps
module stall_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // request
  input wire logic start,
  input wire logic [2:0] cycles,
  // status
  output logic stall
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // counts the halt length down
  assign cnt_nxt = start ? cycles : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
  assign stall = (cnt_r != 3'h0);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// File: hdl/ee_engine.sv
`timescale 1ns/1ps
module ee_engine #(
  parameter int PROG_CYC = dspace_pkg::EE_PROG_CYC
) (
  // clock and power-on reset; system reset does not reach a running write
  input wire logic ref_clk,
  input wire logic por_n,
  // request
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rd_go,
  input wire logic wr_go,
  // result
  output logic [7:0] rdata,
  output logic busy
);
  logic [7:0] mem_r [dspace_pkg::EE_SIZE];
  logic [31:0] cnt_r;
  logic [8:0] wa_r;
  logic [7:0] wd_r;
  logic [7:0] rdata_r;

  assign busy = (cnt_r != 32'h0);
  assign rdata = rdata_r;

  // self timed write; only power-on reset clears the timer
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      cnt_r <= 32'h0;
      wa_r <= 9'h000;
      wd_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      if (wr_go && !busy) begin
        cnt_r <= 32'(PROG_CYC);
        wa_r <= addr;
        wd_r <= wdata;
      end else if (busy) begin
        cnt_r <= cnt_r - 32'h1;
      end
      if (rd_go) begin
        rdata_r <= mem_r[addr];
      end
    end
  end

  // cell array commits at the end of the program time
  always_ff @(posedge ref_clk) begin
    if (cnt_r == 32'h1) begin
      mem_r[wa_r] <= wd_r;
    end
  end
endmodule

// File: bench/region_model.sv
`timescale 1ns/1ps
// far-side regions answering in the same cycle as their select
module region_model (
  // selects
  input wire logic reg_sel,
  input wire logic [4:0] reg_idx,
  input wire logic ext_sel,
  input wire logic sram_sel,
  input wire logic [9:0] sram_idx,
  // read data
  output logic [7:0] reg_rdata,
  output logic [7:0] ext_rdata,
  output logic [7:0] sram_rdata
);
  // unselected regions show inverted data so a stale byte cannot pass as a hit
  assign reg_rdata = reg_sel ? {3'h1, reg_idx} : ~{3'h1, reg_idx};
  assign ext_rdata = ext_sel ? 8'hee : 8'h11;
  assign sram_rdata = sram_sel ? (sram_idx[7:0] ^ 8'h5a) : ~(sram_idx[7:0] ^ 8'h5a);
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk, rstn, por_n, flag_event, io_rd, io_wr, skip, cpu_stall, reg_sel, ext_sel, sram_sel;
  logic ss, sc, sk1, sk0;
  dspace_pkg::op_t op;
  logic [15:0] base_addr;
  logic [5:0] disp, io_addr;
  logic [7:0] wdata, rdata, reg_rdata, ext_rdata, sram_rdata;
  logic [2:0] bit_sel, sv;
  logic [4:0] reg_idx;
  logic [9:0] sram_idx;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [15:0] n;
  logic [15:0] at [6] = '{16'h001f, 16'h0060, 16'h00ff, 16'h0100, 16'h04ff, 16'h0500};
  logic [7:0] ed [6] = '{8'h3f, 8'hee, 8'hee, 8'h5a, 8'ha5, 8'h00};
  logic [2:0] es [6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0};

  // short program time keeps the self-timed write inside the run
  data_space_io_decoder #(.PROG_CYC(40)) dut (.ref_clk(ref_clk), .rstn(rstn), .por_n(por_n),
    .op(op), .base_addr(base_addr), .disp(disp), .wdata(wdata), .rdata(rdata),
    .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .set_io_bit_op(ss), .clear_io_bit_op(sc),
    .skip_if_io_bit_set(sk1), .skip_if_io_bit_clear(sk0), .bit_sel(bit_sel), .skip(skip),
    .reg_idx(reg_idx), .reg_sel(reg_sel), .ext_sel(ext_sel), .sram_idx(sram_idx),
    .sram_sel(sram_sel), .ext_rdata(ext_rdata), .reg_rdata(reg_rdata), .sram_rdata(sram_rdata),
    .flag_event(flag_event), .cpu_stall(cpu_stall));
  region_model far (.reg_sel(reg_sel), .reg_idx(reg_idx), .ext_sel(ext_sel), .sram_sel(sram_sel),
    .sram_idx(sram_idx), .reg_rdata(reg_rdata), .ext_rdata(ext_rdata), .sram_rdata(sram_rdata));

  // clock
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one data-space op; selects are captured while the op is on the bus
  task dacc(input dspace_pkg::op_t o, input logic [15:0] a, input logic [5:0] d, input logic [7:0] w);
    @(posedge ref_clk) op <= o;
    base_addr <= a;
    disp <= d;
    wdata <= w;
    #1 sv = {reg_sel, ext_sel, sram_sel};
    @(posedge ref_clk) op <= dspace_pkg::OP_NONE;
    #1;
  endtask

  task iop(input logic r, input logic w, input logic [5:0] a, input logic [7:0] v);
    @(posedge ref_clk) io_rd <= r;
    io_wr <= w;
    io_addr <= a;
    wdata <= v;
    @(posedge ref_clk) io_rd <= 0;
    io_wr <= 0;
    #1;
  endtask

  // k selects set, clear, skip-if-set, skip-if-clear
  task bop(input int k, input logic [5:0] a, input logic [2:0] b);
    @(posedge ref_clk) {ss, sc, sk1, sk0} <= 4'h8 >> k;
    io_addr <= a;
    bit_sel <= b;
    @(posedge ref_clk) {ss, sc, sk1, sk0} <= 4'h0;
    #1;
  endtask

  // stall cycles seen from the strobe onward
  task stalls;
    n = 16'(cpu_stall);
    repeat (8) @(posedge ref_clk) #1 n += 16'(cpu_stall);
  endtask

  task test_done;
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200us n_mismatch++;
    test_done();
  end

  initial begin
    {rstn, por_n, flag_event, io_rd, io_wr, ss, sc, sk1, sk0} = 0;
    op = dspace_pkg::OP_NONE;
    {base_addr, disp, io_addr, wdata, bit_sel} = 0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1;
    por_n <= 1;
    dacc(dspace_pkg::OP_LOAD, 16'h004b, 6'h00, 8'h00); chk(rdata, 16'h0000);
    dacc(dspace_pkg::OP_STORE, 16'h004b, 6'h00, 8'ha5);
    dacc(dspace_pkg::OP_LOAD, 16'h0010, 6'h3b, 8'h00); chk(rdata, 16'h00a5);
    iop(1, 0, 6'h2b, 8'h00); chk(rdata, 16'h00a5);
    iop(0, 1, 6'h2b, 8'h3c);
    dacc(dspace_pkg::OP_LOAD, 16'h004b, 6'h00, 8'h00); chk(rdata, 16'h003c);
    for (int i = 0; i < 6; i++) begin
      dacc(dspace_pkg::OP_LOAD, at[i], 6'h00, 8'h00);
      chk(rdata, ed[i]);
      chk(sv, es[i]);
    end
    // software never writes a reserved address, so only its read side is driven
    iop(1, 0, 6'h3f, 8'h00); chk(rdata, 16'h0000);
    @(posedge ref_clk) flag_event <= 1;
    @(posedge ref_clk) flag_event <= 0;
    iop(0, 1, 6'h16, 8'h00);
    iop(1, 0, 6'h16, 8'h00); chk(rdata, 16'h0001);
    bop(0, 6'h16, 3'h1);
    iop(1, 0, 6'h16, 8'h00); chk(rdata, 16'h0001);
    bop(2, 6'h16, 3'h0); chk(skip, 1'b1);
    bop(3, 6'h16, 3'h0); chk(skip, 1'b0);
    bop(2, 6'h2b, 3'h2); chk(skip, 1'b0);
    bop(1, 6'h2b, 3'h2);
    iop(1, 0, 6'h2b, 8'h00); chk(rdata, 16'h003c);
    iop(0, 1, 6'h16, 8'h01);
    iop(1, 0, 6'h16, 8'h00); chk(rdata, 16'h0000);
    iop(0, 1, 6'h1f, 8'h01); stalls(); chk(n, 16'h0004);
    iop(0, 1, 6'h1f, 8'h02); stalls(); chk(n, 16'h0000);
    iop(0, 1, 6'h21, 8'h5c);
    iop(0, 1, 6'h22, 8'h01);
    iop(0, 1, 6'h20, 8'hc3);
    iop(0, 1, 6'h1f, 8'h04);
    iop(0, 1, 6'h1f, 8'h02); stalls(); chk(n, 16'h0002);
    @(posedge ref_clk) rstn <= 0;
    @(posedge ref_clk) rstn <= 1;
    iop(1, 0, 6'h1f, 8'h00); chk(rdata[3], 1'b0);
    repeat (40) @(posedge ref_clk);
    iop(1, 0, 6'h1f, 8'h00); chk(rdata[3], 1'b1);
    // the system reset cleared the address registers; the cell must hold the byte
    iop(0, 1, 6'h21, 8'h5c);
    iop(0, 1, 6'h22, 8'h01);
    iop(0, 1, 6'h1f, 8'h01);
    iop(1, 0, 6'h20, 8'h00); chk(rdata, 16'h00c3);
    test_done();
  end
endmodule
